// file: adc_buffer_accumulator_ctrl.sv
// Register control for the data buffer word format, buffer mode, fill count
// and channel zero accumulator, reached over a serial register port.
// Assumes conversions arrive on clk; the link clock toggles only while the
// frame select is low, and the frame select stays low a few clk after the last bit.
`timescale 1ns/1ps
`default_nettype none

module adc_buffer_accumulator_ctrl
  import buffer_accum_pkg::*;
#(
  parameter int ACC_WIDTH = 16
) (
  // Device clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // Conversion results
  input  wire logic           conv_done,
  input  wire conversion_type conv_sample,
  // Formatted buffer words
  output var  logic [15:0]    buffer_word,
  output var  logic           buffer_word_strobe,
  // Decoded buffer mode
  output var  logic           mode_stop_burst,
  output var  logic           mode_start_burst,
  output var  logic           mode_pre_alert,
  output var  logic           mode_post_alert,
  // Serial register port
  input  wire logic           link_clk,
  input  wire logic           link_sel_n,
  input  wire logic           link_sdi,
  output var  logic           link_sdo,
  output var  logic           link_sdo_oe
);

  if (ACC_WIDTH != 16) begin : g_width_check
    $error("ACC_WIDTH must be 16 to fit two result bytes");
  end

  // ----------------------------------------------------------------
  // Word formatting
  // ----------------------------------------------------------------
  function automatic logic [15:0] format_word(input logic [1:0] fmt, input conversion_type s);
    logic [2:0] tag;
    tag = s.channel ? CHAN_TAG_ONE : CHAN_TAG_ZERO;
    unique case (fmt)
      FMT_TAG:       format_word = {s.result, tag, 1'b0};
      FMT_TAG_VALID: format_word = {s.result, tag, s.data_valid};
      default:       format_word = {s.result, 4'h0};
    endcase
  endfunction : format_word

  // ----------------------------------------------------------------
  // Link domain: shift in command and data, shift out read data
  // ----------------------------------------------------------------
  logic [5:0] bit_count;
  logic [5:0] next_bit_count;
  logic [7:0] cmd_shift;
  logic [7:0] next_cmd_shift;
  logic [7:0] data_shift;
  logic [7:0] next_data_shift;
  logic [7:0] out_shift;
  logic [7:0] next_out_shift;
  logic       addr_done;
  logic       next_addr_done;
  logic       data_done;
  logic       next_data_done;
  logic       next_sdo;
  logic       next_sdo_oe;
  logic       rdy_meta;
  logic       rdy_sync;
  logic       rd_ready;
  logic [7:0] rdata_hold;

  always_comb begin
    next_bit_count  = (bit_count == COUNT_MAX) ? bit_count : bit_count + 6'h01;
    next_cmd_shift  = cmd_shift;
    next_data_shift = data_shift;
    next_out_shift  = out_shift;
    next_addr_done  = addr_done;
    next_data_done  = data_done;
    next_sdo        = link_sdo;
    next_sdo_oe     = link_sdo_oe;
    if (bit_count < CMD_BITS) begin
      next_cmd_shift = {cmd_shift[6:0], link_sdi};
    end
    if (bit_count == CMD_BITS - 6'h01) begin
      next_addr_done = 1'b1;
    end
    if (!cmd_shift[CMD_RW_BIT] && bit_count >= CMD_BITS && bit_count < WR_DATA_END) begin
      next_data_shift = {data_shift[6:0], link_sdi};
      if (bit_count == WR_DATA_END - 6'h01) begin
        next_data_done = 1'b1;
      end
    end
    if (cmd_shift[CMD_RW_BIT] && bit_count >= RD_LOAD && bit_count < RD_END) begin
      // Late answer from the core shows as a zero byte
      next_out_shift = (bit_count == RD_LOAD) ? (rdy_sync ? rdata_hold : 8'h00) : out_shift;
      next_sdo       = next_out_shift[7];
      next_out_shift = {next_out_shift[6:0], 1'b0};
      next_sdo_oe    = 1'b1;
    end else begin
      next_sdo_oe    = 1'b0;
      next_sdo       = 1'b0;
    end
  end

  // Frame select ends every frame, since the link clock stops between frames
  always_ff @(posedge link_clk or posedge link_sel_n) begin
    if (link_sel_n) begin
      bit_count   <= 6'h00;
      out_shift   <= 8'h00;
      addr_done   <= 1'b0;
      data_done   <= 1'b0;
      link_sdo    <= 1'b0;
      link_sdo_oe <= 1'b0;
      rdy_meta    <= 1'b0;
      rdy_sync    <= 1'b0;
    end else begin
      bit_count   <= next_bit_count;
      out_shift   <= next_out_shift;
      addr_done   <= next_addr_done;
      data_done   <= next_data_done;
      link_sdo    <= next_sdo;
      link_sdo_oe <= next_sdo_oe;
      rdy_meta    <= rd_ready;
      rdy_sync    <= rdy_meta;
    end
  end

  // Kept across frame end so the core can still read them
  always_ff @(posedge link_clk) begin
    cmd_shift  <= next_cmd_shift;
    data_shift <= next_data_shift;
  end

  // ----------------------------------------------------------------
  // Crossing into the device clock
  // ----------------------------------------------------------------
  logic addr_meta;
  logic addr_sync;
  logic addr_seen;
  logic data_meta;
  logic data_sync;
  logic data_seen;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_meta <= 1'b0;
      addr_sync <= 1'b0;
      addr_seen <= 1'b0;
      data_meta <= 1'b0;
      data_sync <= 1'b0;
      data_seen <= 1'b0;
    end else begin
      addr_meta <= addr_done;
      addr_sync <= addr_meta;
      addr_seen <= addr_sync;
      data_meta <= data_done;
      data_sync <= data_meta;
      data_seen <= data_sync;
    end
  end

  // ----------------------------------------------------------------
  // Register core
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_BUSY = 2'b10
  } access_state_type;

  access_state_type     state;
  access_state_type     next_state;
  command_type          cmd;
  command_type          next_cmd;
  logic [7:0]           next_rdata_hold;
  logic                 next_rd_ready;
  buffer_mode_type      mode;
  buffer_mode_type      next_mode;
  logic [1:0]           fmt;
  logic [1:0]           next_fmt;
  logic [3:0]           accumulator_enable;
  logic [3:0]           next_accumulator_enable;
  logic [4:0]           fill_count;
  logic [4:0]           next_fill_count;
  logic [ACC_WIDTH-1:0] acc;
  logic [ACC_WIDTH-1:0] next_acc;
  logic [7:0]           high_shadow;
  logic [7:0]           next_high_shadow;
  logic [15:0]          next_buffer_word;
  logic                 next_buffer_word_strobe;
  logic                 seq_begin;
  logic                 storing;

  always_comb begin
    next_state       = state;
    next_cmd         = cmd;
    next_rdata_hold  = rdata_hold;
    next_rd_ready    = rd_ready;
    next_mode        = mode;
    next_fmt         = fmt;
    next_accumulator_enable      = accumulator_enable;
    next_high_shadow = high_shadow;
    seq_begin        = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (addr_sync && !addr_seen) begin
          next_cmd   = command_type'(cmd_shift);
          next_state = ST_BUSY;
          if (next_cmd.read) begin
            next_rd_ready = 1'b1;
            unique case (next_cmd.offset)
              OFS_FILL_COUNT:  next_rdata_hold = {3'h0, fill_count};
              OFS_ACC_LOW: begin
                next_rdata_hold  = acc[7:0];
                next_high_shadow = acc[15:8];
              end
              OFS_ACC_HIGH:    next_rdata_hold = high_shadow;
              OFS_WORD_FORMAT: next_rdata_hold = {6'h00, fmt};
              OFS_MODE_SELECT: next_rdata_hold = {5'h00, mode};
              OFS_ACC_ENABLE:  next_rdata_hold = {4'h0, accumulator_enable};
              default:         next_rdata_hold = 8'h00;
            endcase
          end
        end
      end
      ST_BUSY: begin
        if (!cmd.read && data_sync && !data_seen) begin
          // Read-only offsets ignore writes
          unique case (cmd.offset)
            OFS_MODE_SELECT: next_mode   = buffer_mode_type'(data_shift[2:0]);
            OFS_WORD_FORMAT: next_fmt    = data_shift[1:0];
            OFS_ACC_ENABLE:  next_accumulator_enable = data_shift[3:0];
            OFS_SEQ_BEGIN:   seq_begin   = data_shift[SEQ_BEGIN_BIT];
            default: ;
          endcase
        end
        if (!addr_sync) begin
          next_rd_ready = 1'b0;
          next_state    = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Buffer fill and accumulation
  // ----------------------------------------------------------------
  always_comb begin
    storing                 = conv_done && (mode != MODE_STOP_BURST);
    next_fill_count         = fill_count;
    next_acc                = acc;
    next_buffer_word        = buffer_word;
    next_buffer_word_strobe = storing;
    if (storing) begin
      next_buffer_word = format_word(fmt, conv_sample);
      // Circular capture modes overwrite, so the count saturates
      if (fill_count != FILL_MAX) begin
        next_fill_count = fill_count + 5'h01;
      end
    end
    // Sum grows only on a finished channel zero conversion with all four enable bits set
    if (conv_done && accumulator_enable == ACC_ON && !conv_sample.channel) begin
      next_acc = acc + ACC_WIDTH'(conv_sample.result);
    end
    if (seq_begin) begin
      next_fill_count = 5'h00;
      next_acc        = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state              <= ST_IDLE;
      cmd                <= '0;
      rdata_hold         <= 8'h00;
      rd_ready           <= 1'b0;
      mode               <= buffer_mode_type'(MODE_RESET);
      fmt                <= FMT_RESET;
      accumulator_enable             <= ACC_RESET;
      fill_count         <= 5'h00;
      acc                <= '0;
      high_shadow        <= 8'h00;
      buffer_word        <= 16'h0000;
      buffer_word_strobe <= 1'b0;
      mode_stop_burst    <= 1'b0;
      mode_start_burst   <= 1'b1;
      mode_pre_alert     <= 1'b0;
      mode_post_alert    <= 1'b0;
    end else begin
      state              <= next_state;
      cmd                <= next_cmd;
      rdata_hold         <= next_rdata_hold;
      rd_ready           <= next_rd_ready;
      mode               <= next_mode;
      fmt                <= next_fmt;
      accumulator_enable             <= next_accumulator_enable;
      fill_count         <= next_fill_count;
      acc                <= next_acc;
      high_shadow        <= next_high_shadow;
      buffer_word        <= next_buffer_word;
      buffer_word_strobe <= next_buffer_word_strobe;
      mode_stop_burst    <= (next_mode == MODE_STOP_BURST);
      mode_start_burst   <= (next_mode == MODE_START_BURST);
      mode_pre_alert     <= (next_mode == MODE_PRE_ALERT);
      mode_post_alert    <= (next_mode == MODE_POST_ALERT);
    end
  end

endmodule : adc_buffer_accumulator_ctrl

`default_nettype wire

// file: buffer_accum_pkg.sv
// Constants, codes and carriers for the buffer and accumulator control block.
// Assumes one device clock plus a serial link clock that runs only inside frames.
package buffer_accum_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [6:0] OFS_FILL_COUNT  = 7'h01;
  localparam logic [6:0] OFS_ACC_LOW     = 7'h08;
  localparam logic [6:0] OFS_ACC_HIGH    = 7'h09;
  localparam logic [6:0] OFS_SEQ_BEGIN   = 7'h1E;
  localparam logic [6:0] OFS_WORD_FORMAT = 7'h28;
  localparam logic [6:0] OFS_MODE_SELECT = 7'h2C;
  localparam logic [6:0] OFS_ACC_ENABLE  = 7'h30;

  // ----------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_STOP_BURST  = 3'h0,
    MODE_START_BURST = 3'h1,
    MODE_PRE_ALERT   = 3'h4,
    MODE_POST_ALERT  = 3'h6
  } buffer_mode_type;

  localparam logic [2:0] MODE_RESET      = 3'h1;
  localparam logic [1:0] FMT_PLAIN       = 2'h0;
  localparam logic [1:0] FMT_TAG         = 2'h1;
  localparam logic [1:0] FMT_TAG_VALID   = 2'h2;
  localparam logic [1:0] FMT_RESET       = 2'h0;
  localparam logic [3:0] ACC_ON          = 4'hF;
  localparam logic [3:0] ACC_RESET       = 4'h0;
  localparam logic [2:0] CHAN_TAG_ZERO   = 3'h0;
  localparam logic [2:0] CHAN_TAG_ONE    = 3'h1;
  localparam logic [4:0] FILL_MAX        = 5'h10;
  localparam int         SEQ_BEGIN_BIT   = 0;

  // ----------------------------------------------------------------
  // Serial frame layout, in link clock bits
  // ----------------------------------------------------------------
  localparam logic [5:0] CMD_BITS     = 6'h08;
  localparam logic [5:0] WR_DATA_END  = 6'h10;
  localparam logic [5:0] RD_LOAD      = 6'h10;
  localparam logic [5:0] RD_END       = 6'h18;
  localparam logic [5:0] COUNT_MAX    = 6'h3F;
  localparam int         CMD_RW_BIT   = 7;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [11:0] result;
    logic        channel;
    logic        data_valid;
  } conversion_type;

  typedef struct packed {
    logic        read;
    logic [6:0]  offset;
  } command_type;

endpackage : buffer_accum_pkg

// file: adc_buffer_accumulator_ctrl_monitor.sv
// Port checks for the buffer and accumulator control block.
// Assumes link events never coincide with clk edges.
`timescale 1ns/1ps
`default_nettype none
module accum_ctrl_monitor
  import buffer_accum_pkg::*;
#(
  parameter int ACC_WIDTH = 16
) (
  // Device side
  input wire logic           clk,
  input wire logic           sys_rst,
  input wire logic           conv_done,
  input wire conversion_type conv_sample,
  input wire logic [15:0]    buffer_word,
  input wire logic           buffer_word_strobe,
  input wire logic           mode_stop_burst,
  input wire logic           mode_start_burst,
  input wire logic           mode_pre_alert,
  input wire logic           mode_post_alert,
  // Serial link
  input wire logic           link_clk,
  input wire logic           link_sel_n,
  input wire logic           link_sdi,
  input wire logic           link_sdo,
  input wire logic           link_sdo_oe
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_reset_state: assert property ($fell(sys_rst) |->
    mode_start_burst && !buffer_word_strobe && buffer_word == 16'h0000) else $error("bad state after reset");
  chk_mode_decode: assert property ($onehot0({mode_stop_burst, mode_start_burst,
    mode_pre_alert, mode_post_alert})) else $error("several modes decoded");
  chk_strobe_follows: assert property (conv_done && !mode_stop_burst |=>
    buffer_word_strobe) else $error("strobe missing after conversion");
  chk_stop_quiet: assert property (conv_done && mode_stop_burst |=>
    !buffer_word_strobe) else $error("strobe in stop mode");
  chk_strobe_cause: assert property (buffer_word_strobe |->
    $past(conv_done)) else $error("strobe without conversion");
  chk_word_result: assert property (conv_done && !mode_stop_burst |=>
    buffer_word[15:4] == $past(conv_sample.result)) else $error("result field wrong");
  chk_tag_bits: assert property (buffer_word_strobe |-> buffer_word[3:2] == 2'h0 &&
    (buffer_word[1] == 1'h0 || buffer_word[1] == $past(conv_sample.channel))) else $error("tag bits wrong");
  // A mid-run reset clears the word, so the edge after release is excused
  chk_word_hold: assert property (!buffer_word_strobe && !$past(sys_rst) |->
    $stable(buffer_word)) else $error("word changed without strobe");
  chk_oe_quiet: assert property (link_sel_n && $past(link_sel_n) |->
    !link_sdo_oe) else $error("link driven outside frame");
endmodule : accum_ctrl_monitor
bind adc_buffer_accumulator_ctrl accum_ctrl_monitor #(.ACC_WIDTH(ACC_WIDTH)) mon (
  .clk(clk), .sys_rst(sys_rst), .conv_done(conv_done), .conv_sample(conv_sample),
  .buffer_word(buffer_word), .buffer_word_strobe(buffer_word_strobe),
  .mode_stop_burst(mode_stop_burst), .mode_start_burst(mode_start_burst),
  .mode_pre_alert(mode_pre_alert), .mode_post_alert(mode_post_alert),
  .link_clk(link_clk), .link_sel_n(link_sel_n), .link_sdi(link_sdi),
  .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));
`default_nettype wire

// file: host_link_model.sv
// Host processor on the serial register port.
// Assumes the bench calls it at a clk falling edge; a 3 ns offset keeps link edges off clk edges.
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // Host to device
  output var logic link_clk,
  output var logic link_sel_n,
  output var logic link_sdi,
  // Device to host
  input  wire logic link_sdo,
  input  wire logic link_sdo_oe
);
  // ----------------------------------------------------------------
  // Frames
  // ----------------------------------------------------------------
  // Rising select after time zero, so the link logic sees its reset edge
  initial begin
    link_clk = 1'h0;
    link_sel_n = 1'h0;
    link_sdi = 1'h0;
    #1 link_sel_n = 1'h1;
  end
  // Clock stands still between frames; released data line shows inverted last bit
  task automatic frame(input logic [7:0] cmd, input logic [7:0] wd, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #3 link_sel_n = 1'h0;
    for (int i = 0; i < n; i++) begin
      link_sdi = (i < 8) ? cmd[7-i] : (i < 16 && !cmd[7]) ? wd[15-i] : ~link_sdi;
      #16 link_clk = 1'h1;
      #16 link_clk = 1'h0;
      // Undriven data line reads as the inverse of the device's level
      if (i >= 16) rd = {rd[6:0], link_sdo_oe ? link_sdo : ~link_sdo};
    end
    #40 link_sel_n = 1'h1;
    link_sdi = ~link_sdi;
    #48;
  endtask : frame
  task automatic write_reg(input logic [6:0] ofs, input logic [7:0] d);
    logic [7:0] junk;
    frame({1'h0, ofs}, d, 16, junk);
  endtask : write_reg
  task automatic read_reg(input logic [6:0] ofs, output logic [7:0] d);
    frame({1'h1, ofs}, 8'h00, 24, d);
  endtask : read_reg
endmodule : host_link_model
`default_nettype wire

// file: test_adc_buffer_accumulator_ctrl.sv
// Self-checking bench for the buffer and accumulator control block.
// Assumes the host model owns the link; conversions are driven on clk falling edges.
`timescale 1ns/1ps
`default_nettype none
module test_adc_buffer_accumulator_ctrl import buffer_accum_pkg::*;;
  logic           clk = 1'h0;
  logic           sys_rst = 1'h1;
  logic           conv_done = 1'h0;
  conversion_type conv_sample = '0;
  logic [15:0]    buffer_word;
  logic           buffer_word_strobe, mode_stop_burst, mode_start_burst, mode_pre_alert, mode_post_alert;
  logic           link_clk, link_sel_n, link_sdi, link_sdo, link_sdo_oe;
  logic [7:0]     rd;
  int             err_count = 0;
  int             n_compared = 0;
  always #4 clk = ~clk;
  adc_buffer_accumulator_ctrl #(.ACC_WIDTH(16)) uut (.clk(clk), .sys_rst(sys_rst), .conv_done(conv_done),
    .conv_sample(conv_sample), .buffer_word(buffer_word), .buffer_word_strobe(buffer_word_strobe),
    .mode_stop_burst(mode_stop_burst), .mode_start_burst(mode_start_burst), .mode_pre_alert(mode_pre_alert),
    .mode_post_alert(mode_post_alert), .link_clk(link_clk), .link_sel_n(link_sel_n), .link_sdi(link_sdi),
    .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));
  host_link_model host (.link_clk(link_clk), .link_sel_n(link_sel_n), .link_sdi(link_sdi),
    .link_sdo(link_sdo), .link_sdo_oe(link_sdo_oe));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic rd_chk(input logic [6:0] ofs, input logic [7:0] exp);
    host.read_reg(ofs, rd);
    check($sformatf("reg %h", ofs), {8'h00, rd}, {8'h00, exp});
  endtask : rd_chk
  task automatic conv(input logic [11:0] r, input logic ch, input logic v);
    @(negedge clk);
    conv_done = 1'h1;
    conv_sample = '{result: r, channel: ch, data_valid: v};
    @(negedge clk);
    conv_done = 1'h0;
  endtask : conv
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("start", {15'h0000, mode_start_burst}, 16'h0001);
    rd_chk(OFS_FILL_COUNT, 8'h00);
    rd_chk(OFS_ACC_LOW, 8'h00);
    rd_chk(OFS_ACC_HIGH, 8'h00);
    rd_chk(OFS_WORD_FORMAT, 8'h00);
    rd_chk(OFS_MODE_SELECT, 8'h01);
    rd_chk(OFS_ACC_ENABLE, 8'h00);
    rd_chk(7'h05, 8'h00);
  endtask : t_reset
  task automatic t_modes;
    logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h4, 3'h6};
    for (int i = 0; i < 4; i++) begin
      host.write_reg(OFS_MODE_SELECT, {5'h1F, codes[i]});
      rd_chk(OFS_MODE_SELECT, {5'h00, codes[i]});
      check("mode", {12'h000, mode_stop_burst, mode_start_burst, mode_pre_alert, mode_post_alert},
        {12'h000, 4'h8 >> i});
      conv(12'h5A5, 1'h0, 1'h1);
      check("strobe", {15'h0000, buffer_word_strobe}, {15'h0000, i != 0});
    end
    host.write_reg(OFS_MODE_SELECT, 8'h01);
  endtask : t_modes
  task automatic t_formats;
    logic [15:0] exp;
    for (int f = 0; f < 4; f++) begin
      host.write_reg(OFS_WORD_FORMAT, 8'hFC | 8'(f));
      rd_chk(OFS_WORD_FORMAT, 8'(f));
      for (int c = 0; c < 2; c++) begin
        conv(12'hA5C, c[0], !c[0]);
        exp = {12'hA5C, 4'h0};
        if (f == 1) exp[3:0] = {3'(c), 1'h0};
        if (f == 2) exp[3:0] = {3'(c), !c[0]};
        check("word", buffer_word, exp);
      end
    end
    host.write_reg(OFS_WORD_FORMAT, 8'h00);
  endtask : t_formats
  task automatic t_fill;
    host.write_reg(OFS_SEQ_BEGIN, 8'h01);
    rd_chk(OFS_FILL_COUNT, 8'h00);
    repeat (5) conv(12'h111, 1'h0, 1'h1);
    rd_chk(OFS_FILL_COUNT, 8'h05);
    repeat (12) conv(12'h222, 1'h1, 1'h1);
    rd_chk(OFS_FILL_COUNT, 8'h10);
    host.write_reg(OFS_SEQ_BEGIN, 8'h01);
    rd_chk(OFS_FILL_COUNT, 8'h00);
  endtask : t_fill
  task automatic t_accum;
    host.write_reg(OFS_ACC_ENABLE, 8'hFF);
    rd_chk(OFS_ACC_ENABLE, 8'h0F);
    host.write_reg(OFS_SEQ_BEGIN, 8'h01);
    repeat (3) conv(12'hFFF, 1'h0, 1'h1);
    conv(12'h123, 1'h1, 1'h1);
    host.write_reg(OFS_ACC_LOW, 8'h55);
    rd_chk(OFS_ACC_LOW, 8'hFD);
    conv(12'h003, 1'h0, 1'h1);
    rd_chk(OFS_ACC_HIGH, 8'h2F);
    host.write_reg(OFS_ACC_ENABLE, 8'h00);
    conv(12'hFFF, 1'h0, 1'h1);
    rd_chk(OFS_ACC_LOW, 8'h00);
    rd_chk(OFS_ACC_HIGH, 8'h30);
    host.write_reg(OFS_SEQ_BEGIN, 8'h01);
    rd_chk(OFS_ACC_LOW, 8'h00);
    rd_chk(OFS_ACC_HIGH, 8'h00);
  endtask : t_accum
  task automatic t_rerun;
    host.write_reg(OFS_ACC_ENABLE, 8'h0F);
    host.write_reg(OFS_MODE_SELECT, 8'h06);
    conv(12'h0F0, 1'h0, 1'h1);
    @(negedge clk);
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    sys_rst = 1'h0;
    check("start", {15'h0000, mode_start_burst}, 16'h0001);
    repeat (2) @(negedge clk);
    rd_chk(OFS_FILL_COUNT, 8'h00);
    rd_chk(OFS_ACC_LOW, 8'h00);
    rd_chk(OFS_MODE_SELECT, 8'h01);
    rd_chk(OFS_ACC_ENABLE, 8'h00);
  endtask : t_rerun
  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up;
    if (err_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'h0;
    repeat (2) @(negedge clk);
    t_reset();
    t_modes();
    t_formats();
    t_fill();
    t_accum();
    t_rerun();
    wrap_up();
  end
  // About 49 frames of under 1 us each, with wide margin
  initial begin
    #200000;
    err_count++;
    wrap_up();
  end
endmodule : test_adc_buffer_accumulator_ctrl
`default_nettype wire
